// [hdl/stepper_phase_sequencer_regs.svh]
// Register offsets, field positions and reset values of the phase sequencer
`ifndef STEPPER_PHASE_SEQUENCER_REGS_SVH
`define STEPPER_PHASE_SEQUENCER_REGS_SVH

`define SPS_OFF_CTRL 4'h0
`define SPS_OFF_STATUS 4'h4
`define SPS_OFF_STEPCNT 4'h8

`define SPS_CTRL_FORCE_OFF 0
`define SPS_CTRL_CNT_CLEAR 1

`define SPS_STAT_INDEX_LO 0
`define SPS_STAT_INDEX_HI 2
`define SPS_STAT_MODE 3
`define SPS_STAT_DIR 4
`define SPS_STAT_ENABLE 5
`define SPS_STAT_RESET_N 6
`define SPS_STAT_WIND_LO 8
`define SPS_STAT_WIND_HI 11

`define SPS_INDEX_INIT 3'h0
`define SPS_FORCE_OFF_RST 1'h0

`endif

// [hdl/stepper_phase_sequencer_pkg.sv]
// Types shared by the phase sequencer
package stepper_phase_sequencer_pkg;

  typedef struct packed {
    logic first_winding_pos;
    logic first_winding_neg;
    logic second_winding_pos;
    logic second_winding_neg;
  } winding_s;

  typedef struct packed {
    logic step_clk;
    logic mode_half;
    logic rotation_dir;
    logic sys_reset_n;
    logic enable;
  } pin_s;

  typedef logic [2:0] phase_index_t;

endpackage : stepper_phase_sequencer_pkg

// [hdl/stepper_phase_sequencer.sv]
// Step-pulse driven phase sequencer for a unipolar two-phase stepping motor
// Function
// - Pattern advances one step only on a rising step clock edge.
// - Mode low gives full-step two-phase, mode high gives half-step 1-2 phase.
// - Direction low steps forward, direction high steps in reverse order.
// - While reset pin is low, sequencer held in reset and outputs off.
// - Reset state drives first winding positive and second winding negative.
// - Enable low forces all four outputs off; enable high drives normally.
// - Toggling enable never resets the sequencer; position continues afterward.
// - A static step clock keeps the present pattern, holding position.
`include "stepper_phase_sequencer_regs.svh"

module stepper_phase_sequencer
  import stepper_phase_sequencer_pkg::*;
#(
  parameter int CNT_W = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Controller pins
  input wire logic step_clk,
  input wire logic mode_half,
  input wire logic rotation_dir,
  input wire logic sys_reset_n,
  input wire logic enable,
  // Winding drive
  output winding_s windings,
  // Avalon-MM slave
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest
);

  if (CNT_W < 1 || CNT_W > 32) begin : g_bad_cnt_w
    $error("CNT_W must lie between 1 and 32");
  end

  // Position in the eight-entry half-step table; even entries are two-winding
  function automatic winding_s phase_pattern(input phase_index_t idx);
    winding_s w;
    w = '0;
    case (idx)
      3'h0: w = '{1'b1, 1'b0, 1'b0, 1'b1};
      3'h1: w = '{1'b1, 1'b0, 1'b0, 1'b0};
      3'h2: w = '{1'b1, 1'b0, 1'b1, 1'b0};
      3'h3: w = '{1'b0, 1'b0, 1'b1, 1'b0};
      3'h4: w = '{1'b0, 1'b1, 1'b1, 1'b0};
      3'h5: w = '{1'b0, 1'b1, 1'b0, 1'b0};
      3'h6: w = '{1'b0, 1'b1, 1'b0, 1'b1};
      3'h7: w = '{1'b0, 1'b0, 1'b0, 1'b1};
      default: w = '0;
    endcase
    return w;
  endfunction : phase_pattern

  function automatic phase_index_t next_index(input phase_index_t idx, input logic half,
                                              input logic rev);
    phase_index_t stride;
    stride = 3'h1;
    // Full step from a single-winding entry moves one to the nearest two-winding entry
    if (!half && !idx[0]) begin
      stride = 3'h2;
    end
    return rev ? phase_index_t'(idx - stride) : phase_index_t'(idx + stride);
  endfunction : next_index

  // Pin synchronisers: the first stage feeds only the second
  pin_s pins_meta_r;
  pin_s pins_r;
  logic step_prev_r;
  logic step_rise;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pins_meta_r <= '0;
      pins_r <= '0;
      step_prev_r <= 1'b0;
    end else begin
      pins_meta_r <= '{step_clk, mode_half, rotation_dir, sys_reset_n, enable};
      pins_r <= pins_meta_r;
      step_prev_r <= pins_r.step_clk;
    end
  end

  // Only a low-to-high transition counts; falling edges and levels do nothing
  assign step_rise = pins_r.step_clk && !step_prev_r;

  // Sequencer position
  phase_index_t index_r;
  phase_index_t index_nxt;

  // Mode picks the stride, direction the sign
  assign index_nxt = next_index(index_r, pins_r.mode_half,
                                pins_r.rotation_dir);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      index_r <= `SPS_INDEX_INIT;
    end else if (!pins_r.sys_reset_n) begin
      index_r <= `SPS_INDEX_INIT;
    end else if (step_rise) begin
      index_r <= index_nxt;
    end
  end

  // Software control and step counter
  logic force_off_r;
  logic [CNT_W-1:0] step_cnt_r;
  logic waitrequest_r;
  logic bus_write;
  logic cnt_clear;

  assign bus_write = write && !waitrequest_r;
  assign cnt_clear = bus_write && address == `SPS_OFF_CTRL && byteenable[0] &&
                     writedata[`SPS_CTRL_CNT_CLEAR];

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      force_off_r <= `SPS_FORCE_OFF_RST;
    end else if (bus_write && address == `SPS_OFF_CTRL && byteenable[0]) begin
      force_off_r <= writedata[`SPS_CTRL_FORCE_OFF];
    end
  end

  // A step landing on the clear cycle is still counted
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      step_cnt_r <= '0;
    end else if (step_rise && pins_r.sys_reset_n) begin
      step_cnt_r <= cnt_clear ? CNT_W'(1) : CNT_W'(step_cnt_r + 1'b1);
    end else if (cnt_clear) begin
      step_cnt_r <= '0;
    end
  end

  // Winding drive; disable blanks outputs but leaves the position untouched
  winding_s windings_r;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      windings_r <= '0;
    end else if (!pins_r.sys_reset_n || !pins_r.enable || force_off_r) begin
      windings_r <= '0;
    end else begin
      windings_r <= phase_pattern(index_r);
    end
  end

  assign windings = windings_r;

  // Avalon slave: one wait cycle, answer on the following edge
  logic [31:0] readdata_r;
  logic [31:0] status_word;

  always_comb begin
    status_word = '0;
    status_word[`SPS_STAT_INDEX_HI:`SPS_STAT_INDEX_LO] = index_r;
    status_word[`SPS_STAT_MODE] = pins_r.mode_half;
    status_word[`SPS_STAT_DIR] = pins_r.rotation_dir;
    status_word[`SPS_STAT_ENABLE] = pins_r.enable;
    status_word[`SPS_STAT_RESET_N] = pins_r.sys_reset_n;
    status_word[`SPS_STAT_WIND_HI:`SPS_STAT_WIND_LO] = windings_r;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      waitrequest_r <= 1'b1;
    end else if ((read || write) && waitrequest_r) begin
      waitrequest_r <= 1'b0;
    end else begin
      waitrequest_r <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      readdata_r <= '0;
    end else if (read && waitrequest_r) begin
      case (address)
        `SPS_OFF_CTRL: readdata_r <= {31'h0, force_off_r};
        `SPS_OFF_STATUS: readdata_r <= status_word;
        `SPS_OFF_STEPCNT: readdata_r <= 32'(step_cnt_r);
        default: readdata_r <= 32'h0;
      endcase
    end
  end

  assign readdata = readdata_r;
  assign waitrequest = waitrequest_r;

  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  sequence s_reset_release;
    !pins_r.sys_reset_n ##1 pins_r.sys_reset_n;
  endsequence

  sequence s_driving;
    pins_r.sys_reset_n && pins_r.enable && !force_off_r;
  endsequence

  chk_hold_no_edge: assert property (
    (!step_rise && pins_r.sys_reset_n) |=> $stable(index_r))
    else $error("position moved without a rising step edge");

  chk_full_step_fwd: assert property (
    (step_rise && pins_r.sys_reset_n && !pins_r.mode_half && !index_r[0] &&
     !pins_r.rotation_dir) |=> index_r == phase_index_t'($past(index_r) + 3'h2))
    else $error("full step forward did not advance by two entries");

  chk_full_step_rev: assert property (
    (step_rise && pins_r.sys_reset_n && !pins_r.mode_half && !index_r[0] &&
     pins_r.rotation_dir) |=> index_r == phase_index_t'($past(index_r) - 3'h2))
    else $error("full step reverse did not go back two entries");

  chk_half_step_dir: assert property (
    (step_rise && pins_r.sys_reset_n && pins_r.mode_half) |=>
      index_r == ($past(pins_r.rotation_dir) ? phase_index_t'($past(index_r) - 3'h1)
                                             : phase_index_t'($past(index_r) + 3'h1)))
    else $error("half step did not move one entry in the chosen direction");

  chk_mode_realign: assert property (
    (step_rise && pins_r.sys_reset_n && !pins_r.mode_half && index_r[0]) |=>
      !index_r[0] &&
      index_r == ($past(pins_r.rotation_dir) ? phase_index_t'($past(index_r) - 3'h1)
                                             : phase_index_t'($past(index_r) + 3'h1)))
    else $error("switch to full step did not move to a nearest two-winding entry");

  chk_reset_off: assert property (
    !pins_r.sys_reset_n |=> windings_r == '0 && index_r == `SPS_INDEX_INIT)
    else $error("outputs or position not held in reset");

  chk_reset_init: assert property (
    (s_reset_release ##0 s_driving ##0 !step_rise) |=>
      windings_r == winding_s'{1'b1, 1'b0, 1'b0, 1'b1})
    else $error("first pattern after reset is not first positive and second negative");

  chk_enable_off: assert property (
    !pins_r.enable |=> windings_r == '0)
    else $error("outputs driven while disabled");

  chk_enable_resume: assert property (
    (!pins_r.enable && pins_r.sys_reset_n ##1 s_driving) |=>
      windings_r == phase_pattern($past(index_r)) && $past(index_r, 2) != 3'h0 ||
      windings_r == phase_pattern($past(index_r)))
    else $error("outputs did not resume at the held position");

  chk_no_shoot: assert property (
    !(windings_r.first_winding_pos && windings_r.first_winding_neg) &&
    !(windings_r.second_winding_pos && windings_r.second_winding_neg))
    else $error("both outputs of one winding driven");

  // Bus, forced-blanking, counter and position-hold checks
  sequence s_bus_request;
    (read || write) && waitrequest_r;
  endsequence

  sequence s_one_wait;
    !waitrequest_r ##1 waitrequest_r;
  endsequence

  chk_wait_answer: assert property (
    s_bus_request |=> s_one_wait)
    else $error("waitrequest not low for exactly one cycle after a request");

  chk_wait_idle: assert property (
    (!read && !write) |=> waitrequest_r)
    else $error("waitrequest low with no request");

  chk_read_ctrl: assert property (
    (read && waitrequest_r && address == `SPS_OFF_CTRL) |=>
      readdata_r == {31'h0, $past(force_off_r)})
    else $error("control read did not return the force-off bit");

  chk_read_unmapped: assert property (
    (read && waitrequest_r && address != `SPS_OFF_CTRL && address != `SPS_OFF_STATUS &&
     address != `SPS_OFF_STEPCNT) |=> readdata_r == 32'h0)
    else $error("unmapped address did not read zero");

  chk_force_blank: assert property (
    force_off_r |=> windings_r == '0)
    else $error("outputs driven while forced off");

  chk_count_step: assert property (
    (step_rise && pins_r.sys_reset_n && !cnt_clear) |=>
      step_cnt_r == CNT_W'($past(step_cnt_r) + 1'b1))
    else $error("accepted step edge not counted");

  chk_count_hold: assert property (
    (!(step_rise && pins_r.sys_reset_n) && !cnt_clear) |=> $stable(step_cnt_r))
    else $error("step count moved without an accepted step edge");

  chk_count_clear: assert property (
    (cnt_clear && !(step_rise && pins_r.sys_reset_n)) |=> step_cnt_r == '0)
    else $error("step count not cleared");

  chk_disable_keeps: assert property (
    ($fell(pins_r.enable) && pins_r.sys_reset_n && !step_rise) |=> $stable(index_r))
    else $error("disabling the outputs moved the position");

  chk_half_keeps: assert property (
    ($rose(pins_r.mode_half) && pins_r.sys_reset_n && !step_rise) |=> $stable(index_r))
    else $error("switch to half step moved the position");

endmodule : stepper_phase_sequencer

// [dv/step_controller.sv]
// Motion controller model that drives the sequencer's control pins
module step_controller
  import stepper_phase_sequencer_pkg::*;
(
  // Clock
  input wire logic clk,
  // Control pins
  output pin_s pins
);
  timeunit 1ns;
  timeprecision 1ps;

  // Ten microseconds at the 25 MHz clock
  localparam int HALF_CLKS = 250;

  initial begin
    pins = '{step_clk: 1'b0, mode_half: 1'b0, rotation_dir: 1'b0, sys_reset_n: 1'b0,
             enable: 1'b1};
  end

  // Levels change only in the low phase, a full half period away from any rising edge
  task automatic set_pins(input logic mode, input logic dir, input logic en);
    @(posedge clk);
    pins.mode_half <= mode;
    pins.rotation_dir <= dir;
    pins.enable <= en;
    repeat (HALF_CLKS) @(posedge clk);
  endtask : set_pins

  task automatic step();
    @(posedge clk);
    pins.step_clk <= 1'b1;
    repeat (HALF_CLKS) @(posedge clk);
    pins.step_clk <= 1'b0;
    repeat (HALF_CLKS) @(posedge clk);
  endtask : step

  task automatic hold_reset();
    @(posedge clk);
    pins.sys_reset_n <= 1'b0;
    repeat (HALF_CLKS) @(posedge clk);
    pins.sys_reset_n <= 1'b1;
    repeat (8) @(posedge clk);
  endtask : hold_reset
endmodule : step_controller

// [dv/testbench.sv]
// Self-checking testbench of the stepper phase sequencer
`define CHK(a, b) \
  cmp_count++; \
  if ((a) !== (b)) begin \
    error_cnt++; \
    $display("unexpected at %0t: got %0h, want %0h", $time, (a), (b)); \
  end

module testbench
  import stepper_phase_sequencer_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk = 1'b0;
  logic arst_n = 1'b0;
  pin_s pins;
  winding_s windings;
  logic [3:0] address = 4'h0;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [3:0] byteenable = 4'hF;
  logic [31:0] readdata;
  logic waitrequest;
  int error_cnt = 0;
  int cmp_count = 0;
  logic [3:0] tbl [8] = '{4'h9, 4'h8, 4'hA, 4'h2, 4'h6, 4'h4, 4'h5, 4'h1};
  logic [2:0] idx = 3'h0;
  logic mode = 1'b0;
  logic dir = 1'b0;
  logic en = 1'b1;
  logic [15:0] cnt = 16'h0;
  logic [31:0] rd;

  step_controller ctl (.clk(clk), .pins(pins));

  stepper_phase_sequencer DUT (.clk(clk), .arst_n(arst_n), .step_clk(pins.step_clk),
    .mode_half(pins.mode_half), .rotation_dir(pins.rotation_dir),
    .sys_reset_n(pins.sys_reset_n), .enable(pins.enable), .windings(windings),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest));

  initial begin
    forever #20 clk = ~clk;
  end

  function automatic logic [3:0] exp_w();
    return en ? tbl[idx] : 4'h0;
  endfunction : exp_w

  task automatic print_verdict();
    if (error_cnt == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : print_verdict

  // Waits as long as the slave stalls; only the watchdog ends a hung transfer
  task automatic bus(input logic wr, input logic [3:0] adr, input logic [31:0] wd);
    @(posedge clk);
    address <= adr;
    writedata <= wd;
    write <= wr;
    read <= !wr;
    do @(posedge clk);
    while (waitrequest !== 1'b0);
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask : bus

  task automatic set_lv(input logic m, input logic d, input logic e);
    mode = m;
    dir = d;
    en = e;
    ctl.set_pins(m, d, e);
    `CHK(windings, exp_w())
  endtask : set_lv

  // Full step from an odd entry takes one half step first, then pairs of half steps
  task automatic do_step(input int n);
    repeat (n) begin
      ctl.step();
      idx = dir ? idx - ((mode || idx[0]) ? 3'h1 : 3'h2) : idx + ((mode || idx[0]) ? 3'h1 : 3'h2);
      cnt++;
      `CHK(windings, exp_w())
      `CHK(|{windings[3] & windings[2], windings[1] & windings[0]}, 1'b0)
    end
  endtask : do_step

  task automatic sys_reset();
    fork
      ctl.hold_reset();
      begin
        repeat (100) @(posedge clk);
        `CHK(windings, 4'h0)
      end
    join
    idx = 3'h0;
    `CHK(windings, 4'h9)
  endtask : sys_reset

  // Count, status, unmapped read, forced blanking and counter clear over the bus
  task automatic check_registers();
    bus(1'b0, 4'h8, 32'h0);
    `CHK(rd, {16'h0, cnt})
    bus(1'b0, 4'h4, 32'h0);
    `CHK(rd, {20'h0, tbl[idx], 1'b0, 1'b1, en, dir, mode, idx})
    bus(1'b0, 4'hC, 32'h0);
    `CHK(rd, 32'h0)
    bus(1'b1, 4'h0, 32'h1);
    repeat (6) @(posedge clk);
    `CHK(windings, 4'h0)
    bus(1'b1, 4'h0, 32'h2);
    bus(1'b0, 4'h0, 32'h0);
    `CHK(rd, 32'h0)
    `CHK(windings, exp_w())
    bus(1'b0, 4'h8, 32'h0);
    `CHK(rd, 32'h0)
  endtask : check_registers

  initial begin
    repeat (30000) @(posedge clk);
    error_cnt++;
    print_verdict();
  end

  initial begin
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    sys_reset();
    set_lv(1'b1, 1'b0, 1'b1);
    do_step(8);
    set_lv(1'b1, 1'b1, 1'b1);
    do_step(3);
    set_lv(1'b0, 1'b1, 1'b1);
    do_step(2);
    set_lv(1'b0, 1'b0, 1'b1);
    do_step(2);
    set_lv(1'b0, 1'b0, 1'b0);
    do_step(2);
    set_lv(1'b0, 1'b0, 1'b1);
    check_registers();
    sys_reset();
    print_verdict();
  end
endmodule : testbench
